// [rtl/aq2c_consts.svh]
// offsets, field positions, reset values, mode codes and timing figures of the queue-2 control
`ifndef AQ2C_CONSTS_SVH
`define AQ2C_CONSTS_SVH

`define AQ2C_OFF_CTRL 12'h000
`define AQ2C_OFF_STAT 12'h004

`define AQ2C_BIT_CIE 15
`define AQ2C_BIT_PIE 14
`define AQ2C_BIT_SSE 13
`define AQ2C_MODE_HI 12
`define AQ2C_MODE_LO 8
`define AQ2C_BIT_RESUME 7
`define AQ2C_PTR_HI 6

`define AQ2C_CTRL_RESET 16'h007f

`define AQ2C_MODE_DIS 5'h00
`define AQ2C_MODE_SW_SS 5'h01
`define AQ2C_MODE_ER_SS 5'h02
`define AQ2C_MODE_EF_SS 5'h03
`define AQ2C_MODE_RSV_A 5'h0f
`define AQ2C_MODE_RSV_B 5'h10
`define AQ2C_MODE_SW_CS 5'h11
`define AQ2C_MODE_ER_CS 5'h12
`define AQ2C_MODE_EF_CS 5'h13
`define AQ2C_MODE_RSV_C 5'h1f
`define AQ2C_TMR_SEL_LO 4'h4
`define AQ2C_TMR_SEL_HI 4'he

`define AQ2C_TMR_EXP_BASE 5'h07
`define AQ2C_LAST_CCW 7'h3f
`define AQ2C_NO_Q2_PTR 7'h40

`define AQ2C_ST_IDLE 3'h0
`define AQ2C_ST_ACTIVE 3'h1
`define AQ2C_ST_PAUSED 3'h2
`define AQ2C_ST_SUSP 3'h3
`define AQ2C_ST_PEND 3'h4

`endif

// [rtl/aq2c_pkg.sv]
// types shared by the queue-2 control block
package aq2c_pkg;

    typedef enum logic [2:0] {
        AQ2C_IDLE,
        AQ2C_ACTIVE,
        AQ2C_PAUSED,
        AQ2C_SUSP,
        AQ2C_PEND
    } aq2c_state_t;

    typedef struct packed {
        logic q2_complete_irq_en;
        logic q2_pause_irq_en;
        logic q2_single_scan_en;
        logic resume;
        logic [4:0] q2_mode_sel;
        logic [6:0] q2_start_ptr;
        logic resume_eff;
        aq2c_state_t st;
        logic [6:0] ptr;
        logic [6:0] sub_start;
        logic busy;
        logic ext_s1;
        logic ext_s2;
        logic ext_prev;
        logic qck_s1;
        logic qck_s2;
        logic qck_prev;
        logic conv_start;
        logic conv_abort;
        logic cmpl_irq;
        logic pause_irq;
        logic retrig;
        logic [31:0] prdata;
        logic pslverr;
    } aq2c_regs_t;

    typedef struct packed {
        logic [16:0] cnt;
        logic tick;
    } aq2c_tmr_t;

endpackage : aq2c_pkg

// [rtl/aq2c_timer.sv]
// power-of-two interval and periodic timer counted in converter clock periods
`include "aq2c_consts.svh"

module aq2c_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic converter_clock_tick,
    input wire logic run,
    input wire logic [3:0] exp_sel,
    output logic tick
);

    aq2c_pkg::aq2c_tmr_t r_q;
    aq2c_pkg::aq2c_tmr_t r_d;
    logic [4:0] shamt;
    logic [17:0] lim_w;

    always_comb begin
        shamt = {1'b0, exp_sel} + `AQ2C_TMR_EXP_BASE;
        lim_w = (18'h00001 << shamt) - 18'h00001;
        r_d = r_q;
        r_d.tick = 1'b0;
        // counter held at zero while stopped so every period starts clean
        if (!run) begin
            r_d.cnt = 17'h00000;
        end else if (converter_clock_tick) begin
            if (r_q.cnt >= lim_w[16:0]) begin
                r_d.cnt = 17'h00000;
                r_d.tick = 1'b1;
            end else begin
                r_d.cnt = r_q.cnt + 17'h00001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign tick = r_q.tick;

endmodule : aq2c_timer

// [rtl/aq2c_top.sv]
// queue-2 mode control and sequencing with its apb register slave
//
// Chosen here: the register addresses and the APB register port.
`include "aq2c_consts.svh"

// Contract
// - completion interrupt when enabled at last word
// - pause interrupt when enabled on paused word
// - single-scan enable reads zero outside test mode; the status register shows it in any mode
// - single-scan enable self-clears after scan completes
// - enable and single mode settable together
// - single modes ignore triggers while enable clear
// - mode field bits 12:8; zero disables
// - codes 00001, 10001 software single/continuous
// - codes 00010/00011 rising/falling edge single scan
// - codes 10010/10011 rising/falling edge continuous
// - codes 00100-01110 interval timer 2^7..2^17
// - codes 10100-11110 periodic timer 2^7..2^17
// - resume at aborted word or subqueue start
// - resume change applies at queue end/mode change
// - 7-bit start pointer in bits 6:0
// - start pointer ends queue 1
// - queue-1 trigger aborts and suspends queue 2
// - start pointer 64 or more: queue 2 empty
// - stop mode restores register to 0x007f
// - reserved modes stay idle
module aq2c_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic test_mode,
    input wire logic stop_mode,
    input wire logic ext_trig,
    input wire logic converter_clock,
    input wire logic q1_trigger,
    input wire logic q1_active,
    input wire logic q1_ccw_read,
    input wire logic [6:0] q1_ccw_ptr,
    output logic q1_end,
    output logic conv_start,
    output logic [6:0] conv_ptr,
    output logic conv_abort,
    input wire logic conv_done,
    input wire logic conv_pause,
    input wire logic conv_eoq,
    output logic q2_complete_irq,
    output logic q2_pause_irq
);

    aq2c_pkg::aq2c_regs_t r_q;
    aq2c_pkg::aq2c_regs_t r_d;

    logic tmr_tick;
    logic tmr_run;
    logic [3:0] tmr_sel;
    logic mode_valid;
    logic mode_single;
    logic mode_soft;
    logic mode_timer;
    logic ext_rise;
    logic ext_fall;
    logic trig;
    logic last_word;
    logic wr_ctrl;
    logic [4:0] new_mode;
    logic [2:0] st_code;

    function automatic logic [2:0] aq2c_code(input aq2c_pkg::aq2c_state_t s);
        logic [2:0] c;
        c = `AQ2C_ST_IDLE;
        unique case (s)
            aq2c_pkg::AQ2C_IDLE: c = `AQ2C_ST_IDLE;
            aq2c_pkg::AQ2C_ACTIVE: c = `AQ2C_ST_ACTIVE;
            aq2c_pkg::AQ2C_PAUSED: c = `AQ2C_ST_PAUSED;
            aq2c_pkg::AQ2C_SUSP: c = `AQ2C_ST_SUSP;
            aq2c_pkg::AQ2C_PEND: c = `AQ2C_ST_PEND;
            default: c = `AQ2C_ST_IDLE;
        endcase
        return c;
    endfunction : aq2c_code

    // mode decode
    always_comb begin
        mode_valid = (r_q.q2_mode_sel != `AQ2C_MODE_DIS)
            && (r_q.q2_mode_sel != `AQ2C_MODE_RSV_A)
            && (r_q.q2_mode_sel != `AQ2C_MODE_RSV_B)
            && (r_q.q2_mode_sel != `AQ2C_MODE_RSV_C);
        mode_single = !r_q.q2_mode_sel[4];
        mode_soft = (r_q.q2_mode_sel == `AQ2C_MODE_SW_SS)
            || (r_q.q2_mode_sel == `AQ2C_MODE_SW_CS);
        mode_timer = (r_q.q2_mode_sel[3:0] >= `AQ2C_TMR_SEL_LO)
            && (r_q.q2_mode_sel[3:0] <= `AQ2C_TMR_SEL_HI);
        tmr_sel = r_q.q2_mode_sel[3:0] - `AQ2C_TMR_SEL_LO;
        // single-scan timer only runs once armed, so its first period starts at the arm
        tmr_run = mode_timer && (!mode_single || r_q.q2_single_scan_en);
    end

    aq2c_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .converter_clock_tick(r_q.qck_s2 && !r_q.qck_prev),
        .run(tmr_run),
        .exp_sel(tmr_sel),
        .tick(tmr_tick)
    );

    // trigger selection
    always_comb begin
        ext_rise = r_q.ext_s2 && !r_q.ext_prev;
        ext_fall = !r_q.ext_s2 && r_q.ext_prev;
        trig = r_q.retrig;
        unique case (r_q.q2_mode_sel)
            `AQ2C_MODE_SW_SS: trig = trig
                || (r_q.q2_single_scan_en && r_q.st == aq2c_pkg::AQ2C_IDLE);
            `AQ2C_MODE_ER_SS, `AQ2C_MODE_ER_CS: trig = trig || ext_rise;
            `AQ2C_MODE_EF_SS, `AQ2C_MODE_EF_CS: trig = trig || ext_fall;
            default: trig = trig || (mode_timer && tmr_tick);
        endcase
        if (mode_single && !r_q.q2_single_scan_en) begin
            trig = 1'b0;
        end
        if (!mode_valid) begin
            trig = 1'b0;
        end
        last_word = conv_eoq || (r_q.ptr == `AQ2C_LAST_CCW);
        wr_ctrl = psel && penable && pwrite && (paddr == `AQ2C_OFF_CTRL);
        new_mode = pwdata[`AQ2C_MODE_HI:`AQ2C_MODE_LO];
        st_code = aq2c_code(r_q.st);
    end

    always_comb begin
        r_d = r_q;
        r_d.ext_s1 = ext_trig;
        r_d.ext_s2 = r_q.ext_s1;
        r_d.ext_prev = r_q.ext_s2;
        r_d.qck_s1 = converter_clock;
        r_d.qck_s2 = r_q.qck_s1;
        r_d.qck_prev = r_q.qck_s2;
        r_d.conv_start = 1'b0;
        r_d.conv_abort = 1'b0;
        r_d.cmpl_irq = 1'b0;
        r_d.pause_irq = 1'b0;
        r_d.retrig = 1'b0;

        unique case (r_q.st)
            aq2c_pkg::AQ2C_IDLE: begin
                if (trig && r_q.q2_start_ptr < `AQ2C_NO_Q2_PTR) begin
                    r_d.ptr = r_q.q2_start_ptr;
                    r_d.sub_start = r_q.q2_start_ptr;
                    r_d.st = q1_active ? aq2c_pkg::AQ2C_PEND : aq2c_pkg::AQ2C_ACTIVE;
                end
            end
            aq2c_pkg::AQ2C_PEND: begin
                if (!q1_active) begin
                    r_d.st = aq2c_pkg::AQ2C_ACTIVE;
                end
            end
            aq2c_pkg::AQ2C_PAUSED: begin
                if (trig) begin
                    r_d.st = q1_active ? aq2c_pkg::AQ2C_PEND : aq2c_pkg::AQ2C_ACTIVE;
                end
            end
            aq2c_pkg::AQ2C_SUSP: begin
                if (!q1_active) begin
                    r_d.st = aq2c_pkg::AQ2C_ACTIVE;
                    r_d.ptr = r_q.resume_eff ? r_q.ptr : r_q.sub_start;
                end
            end
            aq2c_pkg::AQ2C_ACTIVE: begin
                if (q1_trigger) begin
                    r_d.conv_abort = r_q.busy;
                    r_d.busy = 1'b0;
                    r_d.st = aq2c_pkg::AQ2C_SUSP;
                end else if (!r_q.busy) begin
                    r_d.conv_start = 1'b1;
                    r_d.busy = 1'b1;
                end else if (conv_done) begin
                    r_d.busy = 1'b0;
                    r_d.pause_irq = conv_pause && r_q.q2_pause_irq_en;
                    if (last_word) begin
                        r_d.cmpl_irq = r_q.q2_complete_irq_en;
                        r_d.st = aq2c_pkg::AQ2C_IDLE;
                        r_d.resume_eff = r_q.resume;
                        if (mode_single) begin
                            r_d.q2_single_scan_en = 1'b0;
                        end
                        r_d.retrig = (r_q.q2_mode_sel == `AQ2C_MODE_SW_CS);
                    end else begin
                        r_d.ptr = r_q.ptr + 7'h01;
                        if (conv_pause) begin
                            r_d.sub_start = r_q.ptr + 7'h01;
                            // software modes still pause, but retrigger themselves so they resume on the next cycle
                            if (mode_soft) begin
                                r_d.retrig = 1'b1;
                                r_d.st = aq2c_pkg::AQ2C_PAUSED;
                            end else begin
                                r_d.st = aq2c_pkg::AQ2C_PAUSED;
                            end
                        end
                    end
                end
            end
        endcase

        if (!mode_valid) begin
            r_d.st = aq2c_pkg::AQ2C_IDLE;
            r_d.busy = 1'b0;
            r_d.conv_abort = r_q.busy;
        end
        if (r_q.st == aq2c_pkg::AQ2C_IDLE) begin
            r_d.resume_eff = r_q.resume;
        end

        // a write setting the enable wins over the completion clear in the same cycle
        if (wr_ctrl) begin
            r_d.q2_complete_irq_en = pwdata[`AQ2C_BIT_CIE];
            r_d.q2_pause_irq_en = pwdata[`AQ2C_BIT_PIE];
            r_d.q2_single_scan_en = pwdata[`AQ2C_BIT_SSE];
            r_d.q2_mode_sel = new_mode;
            r_d.resume = pwdata[`AQ2C_BIT_RESUME];
            r_d.q2_start_ptr = pwdata[`AQ2C_PTR_HI:0];
            if (new_mode != r_q.q2_mode_sel) begin
                r_d.resume_eff = pwdata[`AQ2C_BIT_RESUME];
                r_d.st = aq2c_pkg::AQ2C_IDLE;
                r_d.busy = 1'b0;
                r_d.conv_abort = r_q.busy;
                r_d.retrig = (new_mode == `AQ2C_MODE_SW_CS);
            end
        end

        if (stop_mode) begin
            {r_d.q2_complete_irq_en, r_d.q2_pause_irq_en, r_d.q2_single_scan_en,
                r_d.q2_mode_sel, r_d.resume, r_d.q2_start_ptr} = `AQ2C_CTRL_RESET;
            r_d.st = aq2c_pkg::AQ2C_IDLE;
            r_d.busy = 1'b0;
            r_d.retrig = 1'b0;
            r_d.conv_start = 1'b0;
            r_d.conv_abort = r_q.busy;
        end

        // read data is captured in the setup phase so the access phase needs no wait
        if (psel && !penable) begin
            r_d.pslverr = 1'b0;
            unique case (paddr)
                `AQ2C_OFF_CTRL: r_d.prdata = {16'h0000, r_q.q2_complete_irq_en,
                    r_q.q2_pause_irq_en, r_q.q2_single_scan_en && test_mode,
                    r_q.q2_mode_sel, r_q.resume, r_q.q2_start_ptr};
                `AQ2C_OFF_STAT: r_d.prdata = {16'h0000, 1'b0, r_q.ptr, 2'b00, r_q.busy,
                    r_q.q2_single_scan_en, r_q.resume_eff, st_code};
                default: begin
                    r_d.prdata = 32'h00000000;
                    r_d.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
            {r_q.q2_complete_irq_en, r_q.q2_pause_irq_en, r_q.q2_single_scan_en,
                r_q.q2_mode_sel, r_q.resume, r_q.q2_start_ptr} <= `AQ2C_CTRL_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // queue 1 ends on reading the word where queue 2 begins; start pointers of 64 or more are compared and can match too
    assign q1_end = q1_ccw_read && (q1_ccw_ptr == r_q.q2_start_ptr);
    assign pready = psel && penable;
    assign pslverr = r_q.pslverr;
    assign prdata = r_q.prdata;
    assign conv_start = r_q.conv_start;
    assign conv_ptr = r_q.ptr;
    assign conv_abort = r_q.conv_abort;
    assign q2_complete_irq = r_q.cmpl_irq;
    assign q2_pause_irq = r_q.pause_irq;

endmodule : aq2c_top

// [verif/aq2c_checker.sv]
// port-level assertions for the queue-2 control block
module aq2c_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stop_mode,
    input wire logic q1_ccw_read,
    input wire logic q1_end,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic conv_pause,
    input wire logic q2_complete_irq,
    input wire logic q2_pause_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_pready_zero_wait: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    a_q1_end_cause: assert property (q1_end |-> q1_ccw_read)
        else $error("queue-1 end without a word read");
    a_start_one_shot: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    a_cmpl_after_done: assert property (q2_complete_irq |-> $past(conv_done))
        else $error("completion request without a finished word");
    a_cmpl_one_shot: assert property (q2_complete_irq |=> !q2_complete_irq)
        else $error("completion request longer than one cycle");
    a_pause_after_done: assert property (q2_pause_irq |-> $past(conv_done && conv_pause))
        else $error("pause request without a paused word");
    a_stop_no_start: assert property (stop_mode ##1 stop_mode |-> !conv_start)
        else $error("conversion started in stop mode");
    a_err_unmapped: assert property (psel && penable && pslverr
        |-> paddr != 12'h000 && paddr != 12'h004)
        else $error("error response on a mapped address");
    a_rd_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
endmodule : aq2c_checker

bind aq2c_top aq2c_checker u_aq2c_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .stop_mode, .q1_ccw_read, .q1_end, .conv_start, .conv_done,
    .conv_pause, .q2_complete_irq, .q2_pause_irq);

// [verif/aq2c_core_model.sv]
// behavioural converter core answering queue-2 conversion requests after a random delay
module aq2c_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_start,
    input wire logic [6:0] conv_ptr,
    input wire logic conv_abort,
    input wire logic [6:0] eoq_ptr,
    input wire logic [6:0] pause_ptr,
    output logic conv_done,
    output logic conv_pause,
    output logic conv_eoq
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_q;
    logic [6:0] ptr_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 0;
            ptr_q <= 7'h00;
            conv_done <= 1'b0;
            conv_pause <= 1'b0;
            conv_eoq <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            // flags are junk between answers so a design that reads them early is caught
            conv_pause <= ~conv_pause;
            conv_eoq <= ~conv_eoq;
            if (conv_start) begin
                wait_q <= 2 + ($urandom % 4);
                ptr_q <= conv_ptr;
            end else if (conv_abort) begin
                wait_q <= 0;
            end else if (wait_q == 1) begin
                wait_q <= 0;
                conv_done <= 1'b1;
                conv_pause <= (ptr_q == pause_ptr);
                conv_eoq <= (ptr_q == eoq_ptr);
            end else if (wait_q > 1) begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule : aq2c_core_model

// [verif/testbench.sv]
// self-checking bench for the queue-2 control block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, test_mode = 0;
    logic stop_mode = 0, ext_trig = 0, converter_clock = 0, q1_trigger = 0, q1_active = 0;
    logic q1_ccw_read = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv, v;
    logic [6:0] q1_ccw_ptr = 0, conv_ptr, ab, eoq_p = 7'h7f, pause_p = 7'h7f;
    logic pready, pslverr, q1_end, conv_start, conv_abort, conv_done, conv_pause, conv_eoq;
    logic q2_complete_irq, q2_pause_irq, erv, rise;
    logic [1:0] cdiv = 0;
    logic [15:0] nz[7] = '{16'h2000, 16'h2f00, 16'h3000, 16'h3f00, 16'h2140, 16'h0210, 16'h0310};
    logic [4:0] em[4] = '{5'h02, 5'h03, 5'h12, 5'h13};
    logic [4:0] tm[2] = '{5'h04, 5'h14};
    logic [6:0] sp[$];
    int sq[$];
    int err_count = 0, check_count = 0, nc = 0, np = 0, na = 0, qe = 0, c0, p0, a0, q0, d, j;

    aq2c_top u_aq2c_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .test_mode, .stop_mode, .ext_trig, .converter_clock, .q1_trigger,
        .q1_active, .q1_ccw_read, .q1_ccw_ptr, .q1_end, .conv_start, .conv_ptr, .conv_abort,
        .conv_done, .conv_pause, .conv_eoq, .q2_complete_irq, .q2_pause_irq);
    aq2c_core_model u_aq2c_core_model (.pclk, .presetn, .conv_start, .conv_ptr, .conv_abort,
        .eoq_ptr(eoq_p), .pause_ptr(pause_p), .conv_done, .conv_pause, .conv_eoq);

    always #50 pclk = ~pclk;
    // converter clock at a quarter of pclk keeps the shortest timer span near 512 cycles
    always @(posedge pclk) begin
        cdiv <= cdiv + 2'd1;
        converter_clock <= cdiv[1];
        qe <= qe + int'(cdiv == 2'd1);
        nc <= nc + int'(q2_complete_irq);
        np <= np + int'(q2_pause_irq);
        na <= na + int'(conv_abort);
        if (conv_start) begin
            sp.push_back(conv_ptr);
            sq.push_back(qe);
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 16) chk(0, 1);
    endtask : apb

    task automatic wr(input logic [15:0] x);
        apb(1'b1, 12'h000, {16'h0000, x});
    endtask : wr

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt

    initial begin
        #5_000_000;
        err_count++;
        results();
    end

    initial begin
        void'($urandom(1924));
        wt(6);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 0);
        chk(rdv, 32'h0000007f);
        apb(1'b0, 12'h008, 0);
        chk({31'h0, erv}, 1);
        chk(rdv, 0);
        for (int k = 0; k < 8; k++) begin
            v = $urandom & 32'h0000e0ff;
            wr(v[15:0]);
            apb(1'b0, 12'h000, 0);
            chk(rdv, v & 32'hffffdfff);
            test_mode <= 1'b1;
            apb(1'b0, 12'h000, 0);
            chk(rdv, v);
            test_mode <= 1'b0;
            q1_ccw_ptr <= v[6:0];
            q1_ccw_read <= 1'b1;
            @(negedge pclk) chk(q1_end, 1);
            @(posedge pclk) q1_ccw_ptr <= v[6:0] + 7'h01;
            @(negedge pclk) chk(q1_end, 0);
            @(posedge pclk) q1_ccw_read <= 1'b0;
        end
        eoq_p <= 7'h12;
        wr(16'h1110);
        wt(20);
        stop_mode <= 1'b1;
        wt(3);
        stop_mode <= 1'b0;
        apb(1'b0, 12'h000, 0);
        chk(rdv, 32'h0000007f);
        foreach (nz[i]) begin
            wr(16'h0000);
            sp.delete();
            wr(nz[i]);
            ext_trig <= 1'b1;
            wt(8);
            ext_trig <= 1'b0;
            wt(40);
            chk(sp.size(), 0);
        end
        foreach (em[i]) begin
            rise = !em[i][0];
            wr(16'h0000);
            ext_trig <= rise;
            wt(6);
            wr({3'b001, em[i], 8'h10});
            wt(6);
            sp.delete();
            ext_trig <= !rise;
            wt(20);
            chk(sp.size(), 0);
            ext_trig <= rise;
            wt(40);
            chk(sp.size() > 0, 1);
        end
        pause_p <= 7'h21;
        eoq_p <= 7'h22;
        for (int k = 0; k < 2; k++) begin
            wr(16'h0000);
            wt(4);
            sp.delete();
            c0 = nc;
            p0 = np;
            wr({k[0], k[0], 1'b1, 5'h01, 8'h20});
            wt(80);
            chk(sp.size(), 3);
            chk(sp[0], 7'h20);
            chk(nc - c0, k);
            chk(np - p0, k);
            test_mode <= 1'b1;
            apb(1'b0, 12'h000, 0);
            chk(rdv[13], 0);
            test_mode <= 1'b0;
        end
        pause_p <= 7'h7f;
        eoq_p <= 7'h13;
        wr(16'h0000);
        wr(16'h1190);
        wt(12);
        j = 0;
        do begin
            @(posedge pclk);
            j++;
        end while (conv_start !== 1'b1 && j < 200);
        q1_trigger <= 1'b1;
        q1_active <= 1'b1;
        ab = conv_ptr;
        a0 = na;
        @(posedge pclk) q1_trigger <= 1'b0;
        wt(10);
        chk(na - a0, 1);
        sp.delete();
        q1_active <= 1'b0;
        wt(60);
        chk(sp[0], ab);
        chk(sp.size() > 4, 1);
        eoq_p <= 7'h10;
        foreach (tm[i]) begin
            wr(16'h0000);
            wt(4);
            sp.delete();
            sq.delete();
            q0 = qe;
            wr({3'b001, tm[i], 8'h10});
            j = 0;
            do begin
                @(posedge pclk);
                j++;
            end while (sq.size() < 1 + tm[i][4] && j < 2000);
            d = tm[i][4] ? sq[1] - sq[0] : sq[0] - q0;
            chk(d inside {[127:130]}, 1);
        end
        results();
    end
endmodule : testbench
